// ===== design/spi_quad_dac_command_slave.sv
// Four-channel 12-bit converter command slave with a Wishbone register view
// How it works
// R1: Full duplex: mosi in, echo out together.
// R2: Select active low; its rise starts conversion.
// R3: Low clear input resets everything asynchronously.
// R4: Master keeps other bus devices disabled.
// R5: Static interface, serial clock up to 50 MHz.
// R6: Master sends command word most significant first.
// R7: Sample mosi on rising serial clock edge.
// R8: Change miso on falling edge; master samples next.
// R9: Master samples bit 31 on first edge.
// R10: Master raises select after all 32 bits.
// R11: Accept both 24-bit and 32-bit frames.
// R12: 32-bit shift register echoes previous word.
// R13: Frame: 8 dummy, command, address, data, 4 dummy.
// R14: Command 0011 writes and updates channels at once.
// R15: Address picks one channel or all.
// R16: Data code is unsigned, scaled by reference.
// R17: Master may ignore the echoed word.
// R18: Deselected: ignore clock and data, hold state.
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module spi_quad_dac_command_slave
  import quad_dac_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [quad_dac_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [quad_dac_pkg::WORD_W-1:0] wb_dat_i,
  output logic [quad_dac_pkg::WORD_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sck,
  input wire logic mosi,
  input wire logic cs_n,
  input wire logic converter_clear_n,
  output logic miso,
  output logic [quad_dac_pkg::CHANNELS-1:0][quad_dac_pkg::CODE_W-1:0] channel_code,
  output logic [quad_dac_pkg::CHANNELS-1:0] channel_update
);
  import quad_dac_pkg::*;

  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic cs_last;
    logic seen_seq;
    logic enable;
    logic length_error;
    logic [FIELD_W-1:0] last_cmd;
    logic [FIELD_W-1:0] last_addr;
    logic [COUNT_W-1:0] frame_count;
    logic [WORD_W-1:0] last_word;
    logic [CHANNELS-1:0][CODE_W-1:0] code;
    logic [CHANNELS-1:0] update;
    logic ack;
    logic [WORD_W-1:0] rdata;
  } sys_t;

  sys_t st;
  sys_t next_st;
  logic frame_end;
  logic frame_new;
  logic frame_ok;
  logic req;
  logic [FIELD_W-1:0] cmd;
  logic [FIELD_W-1:0] addr;
  logic [CODE_W-1:0] data;
  logic [CHANNELS-1:0] target;

  link_word_if lnk ();

  // ****************************************************
  // Serial clock domain
  // ****************************************************
  spi_shift_core shifter (
    .sck(sck),
    .cs_n(cs_n),
    .mosi(mosi),
    .clear_n(converter_clear_n),
    .miso(miso),
    .lnk(lnk.core)
  );

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [CHANNELS-1:0] channel_mask(input logic [FIELD_W-1:0] a);
    logic [CHANNELS-1:0] m;
    m = '0;
    if (a == ADDR_ALL)
      m = '1;
    else if (a < FIELD_W'(CHANNELS))
      m[a[1:0]] = 1'b1;
    return m;
  endfunction : channel_mask

  function automatic logic [ADR_W-1:0] chan_reg(input int i);
    return ADR_W'(REG_CHAN_BASE + ADR_W'(i) * REG_STRIDE);
  endfunction : chan_reg

  // ****************************************************
  // Frame decode
  // ****************************************************
  // Fields sit in the low 24 bits, so both frame lengths decode alike
  assign cmd = lnk.word[CMD_LSB +: FIELD_W]; // R11 R13
  assign addr = lnk.word[ADDR_LSB +: FIELD_W]; // R13
  assign data = lnk.word[DATA_LSB +: CODE_W]; // R13 R16
  assign target = channel_mask(addr); // R15
  // Word is quasi-static here: the master has stopped sck before raising select
  assign frame_end = st.cs_sync & ~st.cs_last; // R2
  assign frame_new = lnk.seq != st.seen_seq;
  assign frame_ok = (lnk.count == FRAME_SHORT) || (lnk.count == FRAME_LONG); // R11
  assign req = wb_cyc_i & wb_stb_i & ~st.ack;

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb
  begin
    next_st = st;
    next_st.cs_meta = cs_n;
    next_st.cs_sync = st.cs_meta;
    next_st.cs_last = st.cs_sync;
    next_st.update = '0;
    next_st.ack = req;
    next_st.rdata = '0;

    // Bus writes before frame events so that a new error wins over a clear
    if (req && wb_we_i)
    begin
      if (wb_adr_i == REG_CTRL)
      begin
        if (wb_sel_i[0])
          next_st.enable = wb_dat_i[CTRL_ENABLE_BIT];
      end
      else if (wb_adr_i == REG_STATUS)
      begin
        if (wb_sel_i[0] && wb_dat_i[STATUS_LEN_ERR_BIT])
          next_st.length_error = 1'b0;
      end
    end

    if (req && !wb_we_i)
    begin
      if (wb_adr_i == REG_CTRL)
      begin
        next_st.rdata[CTRL_ENABLE_BIT] = st.enable;
      end
      else if (wb_adr_i == REG_STATUS)
      begin
        next_st.rdata[STATUS_LEN_ERR_BIT] = st.length_error;
        next_st.rdata[STATUS_CMD_LSB +: FIELD_W] = st.last_cmd;
        next_st.rdata[STATUS_ADDR_LSB +: FIELD_W] = st.last_addr;
        next_st.rdata[STATUS_COUNT_LSB +: COUNT_W] = st.frame_count;
      end
      else if (wb_adr_i == REG_LAST_WORD)
      begin
        next_st.rdata = st.last_word;
      end
      else
      begin
        for (int i = 0; i < CHANNELS; i++)
        begin
          if (wb_adr_i == chan_reg(i))
            next_st.rdata[CODE_W-1:0] = st.code[i];
        end
      end
    end

    // Select with no clocks at all leaves seq untouched and is ignored
    if (frame_end && frame_new)
    begin
      next_st.seen_seq = lnk.seq;
      next_st.frame_count = COUNT_W'(st.frame_count + 16'h0001);
      next_st.last_word = lnk.word;
      next_st.last_cmd = cmd;
      next_st.last_addr = addr;
      if (!frame_ok)
      begin
        next_st.length_error = 1'b1; // R11
      end
      else if (st.enable && cmd == CMD_WRITE_UPDATE) // R14
      begin
        for (int i = 0; i < CHANNELS; i++)
        begin
          if (target[i]) // R15
          begin
            next_st.code[i] = data; // R14 R16
            next_st.update[i] = 1'b1; // R2
          end
        end
      end
    end
  end

  // ****************************************************
  // State register
  // ****************************************************
  always_ff @(posedge clk or negedge converter_clear_n)
  begin
    if (!converter_clear_n) // R3
    begin
      st <= '0;
      st.cs_meta <= 1'b1;
      st.cs_sync <= 1'b1;
      st.cs_last <= 1'b1;
      st.enable <= ENABLE_RESET;
    end
    else if (reset)
    begin
      st <= '0;
      st.cs_meta <= 1'b1;
      st.cs_sync <= 1'b1;
      st.cs_last <= 1'b1;
      st.enable <= ENABLE_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;
  assign channel_code = st.code;
  assign channel_update = st.update;

  // ****************************************************
  // Checks
  // ****************************************************
  a_update_cause: assert property (@(posedge clk) disable iff (reset || !converter_clear_n) // R2
    channel_update != '0 |-> $past(frame_end) && $past(st.enable))
    else $error("channel update without a select rise");
  a_write_all: assert property (@(posedge clk) disable iff (reset || !converter_clear_n) // R14
    frame_end && frame_new && frame_ok && st.enable && cmd == CMD_WRITE_UPDATE
      && addr == ADDR_ALL
    |=> channel_update == '1 && channel_code[CHANNELS-1] == $past(data))
    else $error("broadcast write did not reach all channels");
  a_write_one: assert property (@(posedge clk) disable iff (reset || !converter_clear_n) // R15
    frame_end && frame_new && frame_ok && st.enable && cmd == CMD_WRITE_UPDATE
      && addr == 4'h2
    |=> channel_update == 4'h4 && channel_code[2] == $past(data))
    else $error("single channel write went astray");
  a_other_cmd: assert property (@(posedge clk) disable iff (reset || !converter_clear_n) // R14
    frame_end && cmd != CMD_WRITE_UPDATE |=> channel_update == '0)
    else $error("unsupported command updated a channel");
  a_bad_length: assert property (@(posedge clk) disable iff (reset || !converter_clear_n) // R11
    frame_end && frame_new && !frame_ok |=> st.length_error && channel_update == '0)
    else $error("bad frame length not flagged");
  a_code_hold: assert property (@(posedge clk) disable iff (reset || !converter_clear_n) // R18
    !frame_end |=> $stable(channel_code))
    else $error("channel code moved outside a frame end");
  a_short_write: assert property (@(posedge clk) disable iff (reset || !converter_clear_n) // R11
    frame_end && frame_new && lnk.count == FRAME_SHORT && st.enable
      && cmd == CMD_WRITE_UPDATE
    |=> channel_update == $past(target))
    else $error("short frame write went astray");
  a_disabled_drop: assert property (@(posedge clk) disable iff (reset || !converter_clear_n) // R14
    frame_end && !st.enable |=> channel_update == '0)
    else $error("disabled converter updated a channel");
  a_no_target: assert property (@(posedge clk) disable iff (reset || !converter_clear_n) // R15
    frame_end && addr > FIELD_W'(CHANNELS - 1) && addr != ADDR_ALL
    |=> channel_update == '0)
    else $error("address without a channel updated one");
  a_update_pulse: assert property (@(posedge clk) disable iff (reset || !converter_clear_n) // R2
    channel_update != '0 |=> channel_update == '0)
    else $error("update pulse longer than one cycle");
  a_error_sticky: assert property (@(posedge clk) disable iff (reset || !converter_clear_n) // R11
    st.length_error && !reset && !(req && wb_we_i && wb_adr_i == REG_STATUS && wb_sel_i[0]
      && wb_dat_i[STATUS_LEN_ERR_BIT])
    |=> st.length_error)
    else $error("length error dropped without a clear");
  a_frame_count: assert property (@(posedge clk) disable iff (reset || !converter_clear_n)
    frame_end && frame_new && !reset
    |=> st.frame_count == $past(st.frame_count) + 16'h0001)
    else $error("frame not counted");
  a_seq_follow: assert property (@(posedge clk) disable iff (reset || !converter_clear_n)
    frame_end && frame_new |=> !frame_new)
    else $error("frame taken twice");
  a_ack_single: assert property (@(posedge clk) disable iff (reset || !converter_clear_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  // ****************************************************
  // Bus checks
  // ****************************************************
  a_ack_follows: assert property (@(posedge clk) disable iff (reset || !converter_clear_n)
    req && !reset |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_rdata_idle: assert property (@(posedge clk) disable iff (reset || !converter_clear_n)
    !wb_ack_o |-> wb_dat_o == '0)
    else $error("read data shown without ack");
  a_ack_data: assert property (@(posedge clk) disable iff (reset || !converter_clear_n) // R12
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == REG_LAST_WORD
    |-> wb_dat_o == $past(st.last_word))
    else $error("last word read returned wrong data");
  a_enable_write: assert property (@(posedge clk) disable iff (reset || !converter_clear_n)
    req && !reset && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0]
    |=> st.enable == $past(wb_dat_i[CTRL_ENABLE_BIT]))
    else $error("enable write did not land");
endmodule : spi_quad_dac_command_slave

// ===== inc/quad_dac_pkg.sv
// Constants and field layout shared by the quad converter command slave
package quad_dac_pkg;
  // ****************************************************
  // Frame layout
  // ****************************************************
  localparam int WORD_W = 32;
  localparam int CODE_W = 12;
  localparam int CHANNELS = 4;
  localparam int FIELD_W = 4;
  localparam int CNT_W = 6;
  localparam int CMD_LSB = 20;
  localparam int ADDR_LSB = 16;
  localparam int DATA_LSB = 4;
  localparam logic [CNT_W-1:0] FRAME_SHORT = 6'h18;
  localparam logic [CNT_W-1:0] FRAME_LONG = 6'h20;
  localparam logic [CNT_W-1:0] COUNT_SAT = 6'h21;
  localparam logic [FIELD_W-1:0] CMD_WRITE_UPDATE = 4'h3;
  localparam logic [FIELD_W-1:0] ADDR_ALL = 4'hf;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADR_W-1:0] REG_LAST_WORD = 8'h08;
  localparam logic [ADR_W-1:0] REG_CHAN_BASE = 8'h10;
  localparam logic [ADR_W-1:0] REG_STRIDE = 8'h04;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int STATUS_LEN_ERR_BIT = 0;
  localparam int STATUS_CMD_LSB = 8;
  localparam int STATUS_ADDR_LSB = 12;
  localparam int STATUS_COUNT_LSB = 16;
  localparam int COUNT_W = 16;
  localparam logic ENABLE_RESET = 1'b1;
endpackage : quad_dac_pkg

// ===== inc/link_word_if.sv
// Carrier for the quasi-static frame word between the serial and system domains
`timescale 1ns/1ps
interface link_word_if;
  logic [31:0] word;
  logic [5:0] count;
  logic seq;
  modport core (output word, output count, output seq);
  modport sys (input word, input count, input seq);
endinterface : link_word_if

// ===== design/spi_shift_core.sv
// Serial-clock side shift register, bit counter and echo output
`timescale 1ns/1ps
module spi_shift_core
  import quad_dac_pkg::*;
(
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic clear_n,
  output logic miso,
  link_word_if.core lnk
);
  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic [CNT_W-1:0] count;
    logic seq;
  } link_t;

  link_t st;
  link_t next_st;
  logic fresh;

  // ****************************************************
  // Shift on rising edge
  // ****************************************************
  always_comb
  begin
    next_st = st;
    if (!cs_n) // R18
    begin
      next_st.word = {st.word[WORD_W-2:0], mosi}; // R7 R12
      if (fresh)
      begin
        next_st.count = 6'h01;
        next_st.seq = ~st.seq;
      end
      else if (st.count != COUNT_SAT)
      begin
        next_st.count = 6'(st.count + 6'h01);
      end
    end
  end

  always_ff @(posedge sck or negedge clear_n)
  begin
    if (!clear_n) // R3
      st <= '0;
    else
      st <= next_st;
  end

  // Frame start marker; sck may stand still, so select itself rearms it
  always_ff @(posedge sck or posedge cs_n or negedge clear_n) // R5
  begin
    if (!clear_n)
      fresh <= 1'b1;
    else if (cs_n)
      fresh <= 1'b1;
    else
      fresh <= 1'b0;
  end

  // ****************************************************
  // Echo out on falling edge
  // ****************************************************
  always_ff @(negedge sck or negedge clear_n)
  begin
    if (!clear_n)
      miso <= 1'b0;
    else if (!cs_n)
      miso <= st.word[WORD_W-1]; // R1 R8
  end

  assign lnk.word = st.word;
  assign lnk.count = st.count;
  assign lnk.seq = st.seq;

  a_shift_samples: assert property (@(posedge sck) disable iff (!clear_n) // R7
    !cs_n |=> st.word[0] == $past(mosi))
    else $error("mosi not sampled on rising edge");
  a_echo_falling: assert property (@(negedge sck) disable iff (!clear_n) // R8
    !cs_n |=> miso == $past(st.word[WORD_W-1]))
    else $error("miso not updated from top bit on falling edge");
  a_idle_hold: assert property (@(posedge sck) disable iff (!clear_n) // R18
    cs_n |=> $stable(st.word))
    else $error("shift register moved while deselected");
endmodule : spi_shift_core

// ===== dv/spi_master_model.sv
// Behavioural serial bus master that drives the converter command slave
`timescale 1ns/1ps
module spi_master_model
(
  output logic sck,
  output logic mosi,
  output logic cs_n,
  input wire logic miso
);
  // ****
  // Master side
  // ****
  logic [31:0] echo;
  logic preamp_select_n;
  logic adc_convert_strobe;
  logic parallel_flash_enable_n;

  initial
  begin
    sck = 1'b0;
    mosi = 1'b1;
    cs_n = 1'b1;
    echo = '0;
    preamp_select_n = 1'b1;
    adc_convert_strobe = 1'b0;
    parallel_flash_enable_n = 1'b1;
  end

  // Clock runs inside frames and in idle_clocks, 125 ns period
  task automatic frame(input logic [31:0] word, input int nbits);
    #13 cs_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      mosi = word[i];
      #62.5 sck = 1'b1;
      echo = {echo[30:0], miso};
      #62.5 sck = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    mosi = ~mosi;
  endtask : frame

  // Traffic for another device; released data keeps changing
  task automatic idle_clocks();
    for (int i = 0; i < 8; i++)
    begin
      mosi = ~mosi;
      #62.5 sck = 1'b1;
      #62.5 sck = 1'b0;
    end
  endtask : idle_clocks
endmodule : spi_master_model

// ===== dv/tb_spi_quad_dac_command_slave.sv
// Self-checking bench for the quad converter command slave
`timescale 1ns/1ps
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin errors++; $display("wrong value at %0t: %s", $time, m); end end
module tb_spi_quad_dac_command_slave;
  import quad_dac_pkg::*;
  // ****
  // Harness
  // ****
  logic clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic sck, mosi, cs_n, miso, converter_clear_n;
  logic [ADR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i, channel_update;
  logic [WORD_W-1:0] wb_dat_i, wb_dat_o, q;
  logic [CHANNELS-1:0][CODE_W-1:0] channel_code;
  int errors = 0;
  int n_checks = 0;

  spi_quad_dac_command_slave u_dut (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sck(sck),
    .mosi(mosi), .cs_n(cs_n), .converter_clear_n(converter_clear_n), .miso(miso),
    .channel_code(channel_code), .channel_update(channel_update));
  spi_master_model u_master (.sck(sck), .mosi(mosi), .cs_n(cs_n), .miso(miso));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_of_test();
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic wb(input logic we, input logic [ADR_W-1:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    if (wb_ack_o !== 1'b1)
    begin
      errors++;
      end_of_test();
    end
  endtask : wb

  // Dummy bits nonzero on purpose: they must be ignored
  function automatic logic [31:0] mk(input logic [3:0] c, a, input logic [11:0] d);
    return {8'ha5, c, a, d, 4'h9};
  endfunction : mk

  // Frame, then collect update pulses; select gap is covered too
  task automatic send(input logic [31:0] w, input int nbits, input logic [3:0] exp);
    logic [3:0] upd;
    upd = '0;
    u_master.frame(w, nbits);
    repeat (10)
    begin
      @(posedge clk);
      upd |= channel_update;
    end
    `CHK(upd, exp, "update pulses")
  endtask : send

  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    wb(1'b0, REG_CTRL, '0);
    `CHK(q[CTRL_ENABLE_BIT], ENABLE_RESET, "enable at reset")
    `CHK(channel_code, '0, "codes at reset")
    wb(1'b0, 8'hfc, '0);
    `CHK(q, '0, "unmapped read")
  endtask : t_reset

  task automatic t_writes();
    send(mk(CMD_WRITE_UPDATE, 4'h0, 12'habc), 32, 4'b0001);
    `CHK(channel_code[0], 12'habc, "channel 0 code")
    `CHK(channel_code[1], 12'h000, "channel 1 untouched")
    `CHK(u_master.echo, 32'h0, "echo after clear")
    send(mk(CMD_WRITE_UPDATE, ADDR_ALL, 12'h123), 32, 4'b1111);
    `CHK(u_master.echo, mk(CMD_WRITE_UPDATE, 4'h0, 12'habc), "echo word")
    `CHK(channel_code, {4{12'h123}}, "all channels")
    wb(1'b0, REG_LAST_WORD, '0);
    `CHK(q, mk(CMD_WRITE_UPDATE, ADDR_ALL, 12'h123), "last word")
  endtask : t_writes

  task automatic t_ignored();
    u_master.idle_clocks();
    send(mk(4'h2, 4'h1, 12'h777), 32, 4'b0000);
    `CHK(u_master.echo, mk(CMD_WRITE_UPDATE, ADDR_ALL, 12'h123), "held word")
    `CHK(channel_code, {4{12'h123}}, "codes kept")
    wb(1'b0, REG_STATUS, '0);
    `CHK(q[15:8], 8'h12, "command and address fields")
  endtask : t_ignored

  task automatic t_length();
    send(mk(CMD_WRITE_UPDATE, 4'h1, 12'h444), 16, 4'b0000);
    wb(1'b0, REG_STATUS, '0);
    `CHK(q[STATUS_LEN_ERR_BIT], 1'b1, "length error")
    wb(1'b1, REG_STATUS, 32'h1);
    wb(1'b0, REG_STATUS, '0);
    `CHK(q[STATUS_LEN_ERR_BIT], 1'b0, "length error cleared")
  endtask : t_length

  task automatic t_short();
    wb(1'b1, REG_CTRL, 32'h0);
    send(mk(CMD_WRITE_UPDATE, 4'h3, 12'hfff), 32, 4'b0000);
    wb(1'b1, REG_CTRL, 32'h1);
    send(mk(CMD_WRITE_UPDATE, 4'h2, 12'h5a5), 24, 4'b0100);
    wb(1'b0, REG_CHAN_BASE + 8'h08, '0);
    `CHK(q[11:0], 12'h5a5, "short frame code")
    `CHK(channel_code[3], 12'h123, "disabled write dropped")
  endtask : t_short

  // Checked before the next clk edge, so only an async path passes
  task automatic t_clear();
    @(posedge clk);
    converter_clear_n <= 1'b0;
    #20;
    `CHK(channel_code, '0, "codes cleared")
    `CHK(miso, 1'b0, "echo cleared")
    @(posedge clk);
    converter_clear_n <= 1'b1;
  endtask : t_clear

  initial
  begin
    {reset, wb_cyc_i, wb_stb_i, wb_we_i, converter_clear_n} = 5'b10000;
    wb_adr_i = '0;
    wb_dat_i = '0;
    wb_sel_i = 4'hf;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    converter_clear_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_writes();
    t_ignored();
    t_length();
    t_short();
    t_clear();
    end_of_test();
  end
endmodule : tb_spi_quad_dac_command_slave
